//--- rtl/bwpc_top.sv
`timescale 1ns/100ps
`default_nettype none
module bwpc_top #(
  parameter int LS_DIV = bwpc_pkg::LS_DIV,
  parameter int SCALE_DIV = bwpc_pkg::SCALE_DIV
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic SYS_RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [6:0] WAKE_N_I,
  input wire logic WEEK_ALARM_I,
  input wire logic CLOCK_ALARM_I,
  input wire logic SHUTDOWN_N_I,
  input wire logic POWER_GOOD_I,
  output logic POWER_REQ_O,
  output logic HOLDOFF_N_O
);

  // Byte-enable mask from Wishbone select lines
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : sel_mask

  logic ack_ff;
  logic [31:0] dat_ff;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] rd_mux;
  logic [11:0] ls_cnt_ff;
  logic [11:0] sc_cnt_ff;
  logic ls_tick;
  logic slow_tick;
  logic [6:0] samp_ff;
  logic [6:0] filt_ff;
  logic [6:0] prev_ff;
  logic [6:0] pin_v;
  logic [6:0] buf_on;
  logic [6:0] asserted;
  logic [6:0] in_eff;
  logic [6:0] in_lat_ff;
  logic [6:0] le_ff;
  logic [6:0] in_en_ff;
  logic [6:0] buf_en_ff;
  logic [6:0] pol_ff;
  logic [6:0] rise_ff;
  logic [6:0] fall_ff;
  logic bypass_ff;
  logic week_le_ff;
  logic clk_le_ff;
  logic week_lat_ff;
  logic clk_lat_ff;
  logic week_eff;
  logic clk_eff;
  logic fw_sel_ff;
  logic fw_lvl_ff;
  logic fw_mode;
  logic hw_req;
  logic pwr_ff;
  logic nxt_pwr;
  logic [7:0] hold_cnt_ff;
  logic [7:0] ho_cnt_ff;
  logic sd_prev_ff;
  logic sd_start;
  logic fw_rst_n;
  bwpc_pkg::bwpc_ho_state_t ho_state_ff;

  // Wishbone slave: one wait state, ack drops after one cycle
  assign wr_go = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_ff;
  assign wmask = sel_mask(WB_SEL_I);
  assign wbits = WB_DAT_I & wmask;
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= WB_CYC_I & WB_STB_I & ~ack_ff;
      dat_ff <= (WB_CYC_I & WB_STB_I & ~WB_WE_I & ~ack_ff) ? rd_mux : 32'h0000_0000;
    end
  end

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (WB_ADR_I)
      bwpc_pkg::ADDR_CTRL: begin
        rd_mux[6:0] = buf_on & ~in_eff;
        rd_mux[bwpc_pkg::OUT_BIT] = pwr_ff;
        rd_mux[bwpc_pkg::FW_LVL_BIT] = fw_lvl_ff;
        rd_mux[bwpc_pkg::FW_SEL_BIT] = fw_sel_ff;
        rd_mux[bwpc_pkg::BYPASS_BIT] = bypass_ff;
        rd_mux[bwpc_pkg::WEEK_ALARM_BIT] = week_lat_ff;
        rd_mux[bwpc_pkg::CLK_ALARM_BIT] = clk_lat_ff;
      end
      bwpc_pkg::ADDR_LATCH_EN: begin
        rd_mux[6:0] = le_ff;
        rd_mux[bwpc_pkg::WEEK_ALARM_BIT] = week_le_ff;
        rd_mux[bwpc_pkg::CLK_ALARM_BIT] = clk_le_ff;
      end
      bwpc_pkg::ADDR_IN_EN: rd_mux[6:0] = in_en_ff;
      bwpc_pkg::ADDR_HOLD_CNT: rd_mux[7:0] = hold_cnt_ff;
      bwpc_pkg::ADDR_POLARITY: rd_mux[6:0] = pol_ff;
      bwpc_pkg::ADDR_RISE: rd_mux[6:0] = rise_ff;
      bwpc_pkg::ADDR_FALL: rd_mux[6:0] = fall_ff;
      bwpc_pkg::ADDR_BUF_EN: rd_mux[6:0] = buf_en_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Battery-domain configuration registers
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bypass_ff <= 1'b0;
      le_ff <= bwpc_pkg::LE_RST;
      week_le_ff <= 1'b0;
      clk_le_ff <= 1'b0;
      in_en_ff <= bwpc_pkg::IN_EN_RST;
      buf_en_ff <= bwpc_pkg::BUF_EN_RST;
      pol_ff <= bwpc_pkg::POL_RST;
      hold_cnt_ff <= bwpc_pkg::HOLD_CNT_RST;
    end else if (wr_go) begin
      case (WB_ADR_I)
        bwpc_pkg::ADDR_CTRL: begin
          if (WB_SEL_I[1]) begin
            bypass_ff <= WB_DAT_I[bwpc_pkg::BYPASS_BIT];
          end
        end
        bwpc_pkg::ADDR_LATCH_EN: begin
          le_ff <= (le_ff & ~wmask[6:0]) | wbits[6:0];
          if (WB_SEL_I[2]) begin
            week_le_ff <= WB_DAT_I[bwpc_pkg::WEEK_ALARM_BIT];
            clk_le_ff <= WB_DAT_I[bwpc_pkg::CLK_ALARM_BIT];
          end
        end
        bwpc_pkg::ADDR_IN_EN: in_en_ff <= (in_en_ff & ~wmask[6:0]) | wbits[6:0];
        bwpc_pkg::ADDR_HOLD_CNT: hold_cnt_ff <= (hold_cnt_ff & ~wmask[7:0]) | wbits[7:0];
        bwpc_pkg::ADDR_POLARITY: pol_ff <= (pol_ff & ~wmask[6:0]) | wbits[6:0];
        bwpc_pkg::ADDR_BUF_EN: buf_en_ff <= (buf_en_ff & ~wmask[6:0]) | wbits[6:0];
        default: ;
      endcase
    end
  end

  // Firmware select and level, also cleared by system reset
  assign fw_rst_n = RST_N_I & SYS_RST_N_I;
  always_ff @(posedge CORE_CLK_I or negedge fw_rst_n) begin
    if (!fw_rst_n) begin
      fw_sel_ff <= 1'b0;
      fw_lvl_ff <= 1'b0;
    end else if (wr_go && WB_ADR_I == bwpc_pkg::ADDR_CTRL && WB_SEL_I[1]) begin
      fw_sel_ff <= WB_DAT_I[bwpc_pkg::FW_SEL_BIT];
      fw_lvl_ff <= WB_DAT_I[bwpc_pkg::FW_LVL_BIT];
    end else if (fw_sel_ff && !fw_lvl_ff && !POWER_GOOD_I) begin
      fw_sel_ff <= 1'b0;
    end
  end

  // Low-speed tick from core clock, then scaled to 8 Hz
  assign ls_tick = (ls_cnt_ff == 12'(LS_DIV - 1));
  assign slow_tick = ls_tick & (sc_cnt_ff == 12'(SCALE_DIV - 1));
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ls_cnt_ff <= 12'h000;
      sc_cnt_ff <= 12'h000;
    end else begin
      ls_cnt_ff <= ls_tick ? 12'h000 : ls_cnt_ff + 12'h001;
      if (ls_tick) begin
        sc_cnt_ff <= slow_tick ? 12'h000 : sc_cnt_ff + 12'h001;
      end
    end
  end

  // Glitch filter: pin must match on two low-speed samples
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      samp_ff <= bwpc_pkg::PIN_IDLE;
      filt_ff <= bwpc_pkg::PIN_IDLE;
    end else if (ls_tick) begin
      samp_ff <= WAKE_N_I;
      filt_ff <= (WAKE_N_I & ~(WAKE_N_I ^ samp_ff)) | (filt_ff & (WAKE_N_I ^ samp_ff));
    end
  end

  // Polarity, buffer gating and latch selection
  assign pin_v = bypass_ff ? WAKE_N_I : filt_ff;
  assign buf_on = in_en_ff | buf_en_ff;
  assign asserted = buf_on & (pin_v ^ ~pol_ff); // High when the input is asserted
  assign in_eff = (le_ff & in_lat_ff) | (~le_ff & asserted);
  assign week_eff = WEEK_ALARM_I | (week_le_ff & week_lat_ff);
  assign clk_eff = CLOCK_ALARM_I | (clk_le_ff & clk_lat_ff);

  // Status latches, a set beats a clear in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_lat_ff <= 7'h00;
      week_lat_ff <= 1'b0;
      clk_lat_ff <= 1'b0;
    end else begin
      if (wr_go && WB_ADR_I == bwpc_pkg::ADDR_LATCH_CLR) begin
        in_lat_ff <= (in_lat_ff & ~wbits[6:0]) | (le_ff & asserted);
        week_lat_ff <= (week_lat_ff & ~wbits[bwpc_pkg::WEEK_ALARM_BIT]) | (week_le_ff & WEEK_ALARM_I);
        clk_lat_ff <= (clk_lat_ff & ~wbits[bwpc_pkg::CLK_ALARM_BIT]) | (clk_le_ff & CLOCK_ALARM_I);
      end else begin
        in_lat_ff <= in_lat_ff | (le_ff & asserted);
        week_lat_ff <= week_lat_ff | (week_le_ff & WEEK_ALARM_I);
        clk_lat_ff <= clk_lat_ff | (clk_le_ff & CLOCK_ALARM_I);
      end
    end
  end

  // Edge status before polarity, only while buffer is on
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prev_ff <= bwpc_pkg::PIN_IDLE;
      rise_ff <= 7'h00;
      fall_ff <= 7'h00;
    end else begin
      prev_ff <= pin_v;
      rise_ff <= (rise_ff & ~((wr_go && WB_ADR_I == bwpc_pkg::ADDR_RISE) ? wbits[6:0] : 7'h00))
                 | (buf_on & pin_v & ~prev_ff);
      fall_ff <= (fall_ff & ~((wr_go && WB_ADR_I == bwpc_pkg::ADDR_FALL) ? wbits[6:0] : 7'h00))
                 | (buf_on & ~pin_v & prev_ff);
    end
  end

  // Power-on inhibit timer on low-speed and 8 Hz ticks
  assign sd_start = ls_tick & ~SHUTDOWN_N_I & sd_prev_ff;
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sd_prev_ff <= 1'b1;
      ho_cnt_ff <= 8'h00;
      ho_state_ff <= bwpc_pkg::BWPC_HO_IDLE;
    end else begin
      if (ls_tick) begin
        sd_prev_ff <= SHUTDOWN_N_I;
      end
      if (hold_cnt_ff == 8'h00) begin
        ho_cnt_ff <= 8'h00;
        ho_state_ff <= bwpc_pkg::BWPC_HO_IDLE;
      end else if (sd_start) begin
        ho_cnt_ff <= hold_cnt_ff;
        ho_state_ff <= bwpc_pkg::BWPC_HO_HOLD;
      end else begin
        case (ho_state_ff)
          bwpc_pkg::BWPC_HO_HOLD: begin
            if (slow_tick) begin
              ho_cnt_ff <= ho_cnt_ff - 8'h01;
              if (ho_cnt_ff == 8'h01) begin
                ho_state_ff <= bwpc_pkg::BWPC_HO_IDLE;
              end
            end
          end
          default: ho_state_ff <= bwpc_pkg::BWPC_HO_IDLE;
        endcase
      end
    end
  end
  assign HOLDOFF_N_O = (ho_state_ff != bwpc_pkg::BWPC_HO_HOLD);

  // Output select between firmware level and hardware sources
  assign fw_mode = fw_sel_ff & POWER_GOOD_I;
  assign hw_req = (|(in_en_ff & in_eff)) | week_eff | clk_eff;
  always_comb begin
    if (!HOLDOFF_N_O) begin
      nxt_pwr = 1'b0;
    end else if (fw_mode) begin
      nxt_pwr = fw_lvl_ff;
    end else begin
      nxt_pwr = hw_req;
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pwr_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end
  assign POWER_REQ_O = pwr_ff;

  // Checks on the main behaviour
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_slow_tick_src: assert property (slow_tick |-> ls_tick && sc_cnt_ff == 12'(SCALE_DIV - 1))
    else $error("8 Hz tick not aligned to scale count");
  a_count_decrement: assert property (ho_state_ff == bwpc_pkg::BWPC_HO_HOLD && slow_tick && ho_cnt_ff > 8'h01
    && hold_cnt_ff != 8'h00 && !sd_start |=> ho_cnt_ff == $past(ho_cnt_ff) - 8'h01)
    else $error("Inhibit count did not step down");
  a_holdoff_blocks: assert property (!HOLDOFF_N_O |=> !POWER_REQ_O)
    else $error("Power request during hold-off");
  a_zero_disables: assert property (hold_cnt_ff == 8'h00 |=> HOLDOFF_N_O)
    else $error("Inhibit active with zero count");
  a_shutdown_inhibit: assert property (sd_start && hold_cnt_ff != 8'h00 |=> !HOLDOFF_N_O
    && ho_cnt_ff == $past(hold_cnt_ff))
    else $error("Inhibit not loaded on shutdown");
  a_wake_raises: assert property (HOLDOFF_N_O && !fw_mode && |(in_en_ff & in_eff) |=> POWER_REQ_O)
    else $error("Wake input did not raise request");
  a_week_raises: assert property (HOLDOFF_N_O && !fw_mode && WEEK_ALARM_I |=> POWER_REQ_O)
    else $error("Weekly alarm did not raise request");
  a_fw_level_out: assert property (HOLDOFF_N_O && fw_mode |=> POWER_REQ_O == $past(fw_lvl_ff))
    else $error("Output not following firmware level");
  a_latch_holds: assert property (le_ff[0] && asserted[0] ##1 le_ff[0] && !wr_go [*2]
    |-> in_eff[0])
    else $error("Wake latch lost its assertion");
  a_fw_return: assert property (fw_sel_ff && !fw_lvl_ff && !POWER_GOOD_I && !wr_go |=> !fw_sel_ff)
    else $error("Control did not return to hardware");
  a_clk_alarm_latch: assert property (clk_le_ff && CLOCK_ALARM_I |=> clk_lat_ff)
    else $error("Clock alarm not latched");
  a_week_alarm_latch: assert property (week_le_ff && WEEK_ALARM_I |=> week_lat_ff)
    else $error("Weekly alarm not latched");
  a_hold_release: assert property (ho_state_ff == bwpc_pkg::BWPC_HO_HOLD && slow_tick && ho_cnt_ff == 8'h01
    && hold_cnt_ff != 8'h00 && !sd_start |=> HOLDOFF_N_O ##1 POWER_REQ_O == $past(nxt_pwr))
    else $error("Inhibit not released at zero");

  c_fw_takeover: cover property (fw_mode && fw_lvl_ff ##1 POWER_REQ_O);
  c_holdoff_run: cover property (!HOLDOFF_N_O ##1 HOLDOFF_N_O);
  c_wake_power: cover property (!POWER_REQ_O ##1 POWER_REQ_O && !fw_mode);

endmodule : bwpc_top
`default_nettype wire

//--- shared/bwpc_pkg.sv
`default_nettype none
package bwpc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LATCH_EN = 8'h04;
  localparam logic [7:0] ADDR_LATCH_CLR = 8'h08;
  localparam logic [7:0] ADDR_IN_EN = 8'h0C;
  localparam logic [7:0] ADDR_HOLD_CNT = 8'h10;
  localparam logic [7:0] ADDR_POLARITY = 8'h14;
  localparam logic [7:0] ADDR_RISE = 8'h18;
  localparam logic [7:0] ADDR_FALL = 8'h1C;
  localparam logic [7:0] ADDR_BUF_EN = 8'h20;
  // Field positions
  localparam int CLK_ALARM_BIT = 17;
  localparam int WEEK_ALARM_BIT = 16;
  localparam int BYPASS_BIT = 12;
  localparam int FW_SEL_BIT = 11;
  localparam int FW_LVL_BIT = 10;
  localparam int OUT_BIT = 9;
  localparam int NUM_WAKE = 7;
  localparam int CNT_W = 8;
  // Reset values
  localparam logic [6:0] IN_EN_RST = 7'h7F;
  localparam logic [6:0] BUF_EN_RST = 7'h7F;
  localparam logic [6:0] POL_RST = 7'h00;
  localparam logic [6:0] LE_RST = 7'h00;
  localparam logic [6:0] PIN_IDLE = 7'h7F;
  localparam logic [7:0] HOLD_CNT_RST = 8'h00;
  // Timing
  localparam int CORE_HZ = 125_000_000;
  localparam int LS_HZ = 32_768;
  localparam int SLOW_HZ = 8;
  localparam int SLOW_TICK_MS = 125;
  localparam int LS_DIV = CORE_HZ / LS_HZ;
  localparam int SCALE_DIV = LS_HZ / SLOW_HZ;
  // Inhibit states
  typedef enum logic [0:0] {
    BWPC_HO_IDLE = 1'b0,
    BWPC_HO_HOLD = 1'b1
  } bwpc_ho_state_t;
endpackage : bwpc_pkg
`default_nettype wire

//--- verification/bwpc_partner.sv
`timescale 1ns/100ps
`default_nettype none
module bwpc_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic slow_i,
  input wire logic [6:0] press_i,
  output logic [6:0] wake_n_o,
  output logic pg_o
);
  int cnt_ff;
  // Buttons pull their pin low while pressed
  assign wake_n_o = ~press_i;
  // Regulator ramp: rail good follows the request after a delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 0;
      pg_o <= 1'b0;
    end else if (req_i == pg_o) begin
      cnt_ff <= 0;
    end else if (cnt_ff >= (slow_i ? 20 : 2)) begin
      pg_o <= req_i;
      cnt_ff <= 0;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule : bwpc_partner
`default_nettype wire

//--- verification/bwpc_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bwpc_tb_top;
  localparam int LS = 4;
  localparam int TK = 16;
  logic clk = 1'b0, rst_n = 1'b0, sys_rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic shdn_n = 1'b1, slow = 1'b0, ack, req, hold_n, pg;
  logic [1:0] al = 2'b00;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [6:0] press = 7'h00, wake_n;
  logic [31:0] wdat = 32'h0, rdat, rd;
  int n_fail = 0, samples_checked = 0, e, k;

  // Core clock, 8 ns period
  always #4 clk = ~clk;

  bwpc_top #(.LS_DIV(LS), .SCALE_DIV(4)) dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .SYS_RST_N_I(sys_rst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WAKE_N_I(wake_n),
    .WEEK_ALARM_I(al[0]), .CLOCK_ALARM_I(al[1]), .SHUTDOWN_N_I(shdn_n),
    .POWER_GOOD_I(pg), .POWER_REQ_O(req), .HOLDOFF_N_O(hold_n)
  );

  bwpc_partner rail (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .slow_i(slow), .press_i(press),
    .wake_n_o(wake_n), .pg_o(pg));

  // Value comparison with mismatch report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(rd & m, x);
  endtask : rdchk

  // Wait for a pin level, no sooner than lo and no later than hi cycles
  task automatic wait_pin(input logic h, input logic v, input int lo, input int hi);
    int c;
    logic p;
    c = 0;
    do begin
      @(posedge clk);
      c++;
      p = h ? hold_n : req;
    end while (p !== v && c < hi);
    chk({23'h0, c < lo, 7'h0, p}, {31'h0, v});
  endtask : wait_pin

  // Pin must hold a level for n cycles
  task automatic stays(input logic h, input logic v, input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c += ((h ? hold_n : req) !== v);
    end
    chk(32'(c), 32'h0);
  endtask : stays

  task automatic stop_test();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    sys_rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    // Defaults, read-only fields, unmapped place
    bus(1'b1, 8'h00, 32'hFFFFE3FF);
    rdchk(8'h00, 32'hFFFFFFFF, 32'h7F);
    rdchk(8'h04, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h0C, 32'hFFFFFFFF, 32'h7F);
    rdchk(8'h10, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h14, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h7F);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rdchk(8'h40, 32'hFFFFFFFF, 32'h0);
    // Short glitch filtered, then passed with filters bypassed
    press <= 7'h01;
    repeat (2) @(posedge clk);
    press <= 7'h00;
    stays(1'b0, 1'b0, 20);
    bus(1'b1, 8'h00, 32'h1000);
    press <= 7'h01;
    wait_pin(1'b0, 1'b1, 1, 4);
    press <= 7'h00;
    wait_pin(1'b0, 1'b0, 1, 4);
    bus(1'b1, 8'h00, 32'h0);
    // Wake press, status and polarity
    press <= 7'h01;
    wait_pin(1'b0, 1'b1, 1, 3 * LS);
    rdchk(8'h00, 32'h27F, 32'h27E);
    press <= 7'h00;
    wait_pin(1'b0, 1'b0, 1, 3 * LS);
    bus(1'b1, 8'h14, 32'h1);
    wait_pin(1'b0, 1'b1, 1, 3 * LS);
    rdchk(8'h00, 32'h7F, 32'h7E);
    bus(1'b1, 8'h14, 32'h0);
    wait_pin(1'b0, 1'b0, 1, 3 * LS);
    // Edge status from the presses so far, then write-one-to-clear
    rdchk(8'h18, 32'h7F, 32'h01);
    rdchk(8'h1C, 32'h7F, 32'h01);
    bus(1'b1, 8'h18, 32'h7F);
    bus(1'b1, 8'h1C, 32'h7F);
    rdchk(8'h18, 32'h7F, 32'h00);
    rdchk(8'h1C, 32'h7F, 32'h00);
    // Latched wake press
    bus(1'b1, 8'h04, 32'h1);
    press <= 7'h01;
    repeat (3 * LS) @(posedge clk);
    press <= 7'h00;
    stays(1'b0, 1'b1, 30);
    rdchk(8'h00, 32'h1, 32'h0);
    bus(1'b1, 8'h08, 32'h1);
    wait_pin(1'b0, 1'b0, 1, 3 * LS);
    bus(1'b1, 8'h04, 32'h0);
    // Weekly and clock alarms, plain and latched
    for (int i = 16; i < 18; i++) begin
      al <= 2'b01 << (i - 16);
      wait_pin(1'b0, 1'b1, 1, 3);
      al <= 2'b00;
      wait_pin(1'b0, 1'b0, 1, 3);
      bus(1'b1, 8'h04, 32'h1 << i);
      al <= 2'b01 << (i - 16);
      @(posedge clk);
      al <= 2'b00;
      wait_pin(1'b0, 1'b1, 1, 3);
      stays(1'b0, 1'b1, 10);
      rdchk(8'h00, 32'h1 << i, 32'h1 << i);
      bus(1'b1, 8'h08, 32'h1 << i);
      wait_pin(1'b0, 1'b0, 1, 3);
      rdchk(8'h00, 32'h1 << i, 32'h0);
      bus(1'b1, 8'h04, 32'h0);
    end
    // Firmware takes the output, drops it, rail falls, hardware resumes
    slow <= 1'b1;
    press <= 7'h01;
    wait_pin(1'b0, 1'b1, 1, 3 * LS);
    repeat (25) @(posedge clk);
    bus(1'b1, 8'h00, 32'h400);
    bus(1'b1, 8'h00, 32'hC00);
    press <= 7'h00;
    stays(1'b0, 1'b1, 20);
    press <= 7'h01;
    repeat (3 * LS) @(posedge clk);
    bus(1'b1, 8'h00, 32'h800);
    wait_pin(1'b0, 1'b0, 1, 3);
    rdchk(8'h00, 32'hE7F, 32'h87E);
    wait_pin(1'b0, 1'b1, 5, 40);
    rdchk(8'h00, 32'h800, 32'h0);
    press <= 7'h00;
    slow <= 1'b0;
    wait_pin(1'b0, 1'b0, 1, 3 * LS);
    // System reset clears only select and level
    bus(1'b1, 8'h10, 32'h5A);
    bus(1'b1, 8'h00, 32'h1400);
    bus(1'b1, 8'h00, 32'h1C00);
    sys_rst_n <= 1'b0;
    @(posedge clk);
    sys_rst_n <= 1'b1;
    rdchk(8'h00, 32'h1C00, 32'h1000);
    rdchk(8'h10, 32'hFF, 32'h5A);
    bus(1'b1, 8'h00, 32'h0);
    // Hold-off of three ticks blocks a held button
    bus(1'b1, 8'h10, 32'h3);
    press <= 7'h01;
    wait_pin(1'b0, 1'b1, 1, 3 * LS);
    shdn_n <= 1'b0;
    wait_pin(1'b1, 1'b0, 1, LS + 3);
    shdn_n <= 1'b1;
    e = 0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      e += (k > 3 && req !== 1'b0);
    end while (hold_n !== 1'b1 && k < 4 * TK);
    chk(32'(e), 32'h0);
    chk(32'(k >= 2 * TK - 1 && k <= 3 * TK + 2), 32'h1);
    wait_pin(1'b0, 1'b1, 1, 4);
    // Zero count keeps the inhibit off
    bus(1'b1, 8'h10, 32'h0);
    shdn_n <= 1'b0;
    stays(1'b1, 1'b1, 30);
    shdn_n <= 1'b1;
    press <= 7'h00;
    stop_test();
  end
endmodule : bwpc_tb_top
`default_nettype wire
